// [rtl/dps_pkg.sv]
package dps_pkg;

  // widest values over both configurations: 36-bit words, four lanes, 21 address bits
  localparam int DPS_MAX_DATA_W = 36;
  localparam int DPS_MAX_ADDR_W = 21;
  localparam int DPS_MAX_LANES = 4;
  // each byte write select covers one 9-bit lane
  localparam int DPS_LANE_W = 9;
  // the two documented word widths and their address widths
  localparam int DPS_NARROW_W = 18;
  localparam int DPS_WIDE_W = 36;
  localparam int DPS_NARROW_AW = 21;
  localparam int DPS_WIDE_AW = 20;
  // words moved per access
  localparam int DPS_BURST = 2;
  // depth of the write buffer
  localparam int DPS_WBUF_DEPTH = 8;
  // reset values of the output pins
  localparam logic DPS_OE_N_RST = 1'h1;

  // all pins that arrive from the controller, sampled as one bundle
  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic write_port_select_n;
    logic read_port_select_n;
    logic [DPS_MAX_LANES-1:0] byte_write_select_n;
    logic [DPS_MAX_ADDR_W-1:0] addr;
    logic [DPS_MAX_DATA_W-1:0] wdata;
  } dps_pins_t;

  // one captured write beat: data and its lane selects
  typedef struct packed {
    logic [DPS_MAX_LANES-1:0] byte_write_select_n;
    logic [DPS_MAX_DATA_W-1:0] data;
  } dps_beat_t;

  // one complete write burst waiting for the array
  typedef struct packed {
    logic [DPS_MAX_ADDR_W-1:0] addr;
    dps_beat_t beat0;
    dps_beat_t beat1;
  } dps_wentry_t;

  // read output sequencer, gray along idle -> first -> second
  typedef enum logic [1:0] {
    DPS_OUT_IDLE = 2'h0,
    DPS_OUT_FIRST = 2'h1,
    DPS_OUT_SECOND = 2'h3
  } dps_out_state_t;

endpackage

// [rtl/dps_sram.sv]
`timescale 1ns/1ps
`default_nettype none

// write buffer: simple circular FIFO with valid/ready on both sides
module dps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);

  // pointers carry one extra bit to tell full from empty
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] rd_ptr_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin
      $error("dps_fifo: depth must be a power of two");
    end
  end

  assign in_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {PW{1'b0}}};
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem_reg[rd_ptr_reg[PW-1:0]];

  // storage has no reset; only the pointers matter
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end

  // pointer update
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (PW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (PW+1)'(pop);
    end
  end
endmodule

// burst sram with separate ddr read and write ports
module dps_sram
  import dps_pkg::*;
#(
  parameter int DATA_W = DPS_WIDE_W,
  parameter int ARRAY_AW = (DATA_W == DPS_WIDE_W) ? DPS_WIDE_AW
                                                  : DPS_NARROW_AW,
  parameter int WBUF_DEPTH = DPS_WBUF_DEPTH
) (
  // system clock and synchronous reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // input clock pair and output clock pair from the controller
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  // strap: launch reads on the input clocks
  input wire logic single_clock_mode,
  // port selects, byte selects, shared address, write data
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [DATA_W/DPS_LANE_W-1:0] byte_write_select_n,
  // shared address: 20 bits for 36-bit words, 21 for 18-bit words
  input wire logic [((DATA_W == DPS_WIDE_W) ? DPS_WIDE_AW
                     : DPS_NARROW_AW)-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  // read data pin: output and active-low output enable
  output logic [DATA_W-1:0] rdata,
  output logic rdata_oe_n,
  // write buffer can take another burst
  output logic wbuf_ready
);
  // documented address width for the chosen word width
  localparam int ADDR_W = (DATA_W == DPS_WIDE_W) ? DPS_WIDE_AW
                                                 : DPS_NARROW_AW;
  localparam int LANES = DATA_W / DPS_LANE_W;
  localparam int EW = $bits(dps_wentry_t);

  initial begin
    if (DATA_W != DPS_NARROW_W && DATA_W != DPS_WIDE_W) begin
      $error("dps_sram: word width must be 18 or 36");
    end
    if (ARRAY_AW < 1 || ARRAY_AW > ADDR_W) begin
      $error("dps_sram: array address width out of range");
    end
    if (DPS_BURST != 2) begin
      $error("dps_sram: only a two-word burst is built");
    end
  end

  // two halves: the burst index picks the half, the address the row
  logic [DATA_W-1:0] array_reg [2][2**ARRAY_AW];

  // pins gathered into one bundle, zero-extended to full width
  dps_pins_t pins_raw;
  dps_pins_t sync1_reg;
  dps_pins_t sync2_reg;
  dps_pins_t prev_reg;
  logic mode_s1_reg;
  logic mode_reg;

  assign pins_raw = '{k: k, k_n: k_n, c: c, c_n: c_n,
                      write_port_select_n: write_port_select_n,
                      read_port_select_n: read_port_select_n,
                      byte_write_select_n: DPS_MAX_LANES'(byte_write_select_n),
                      addr: DPS_MAX_ADDR_W'(addr),
                      wdata: DPS_MAX_DATA_W'(wdata)};

  // two-flop synchroniser; all pins share delay so beats stay aligned
  always_ff @(posedge sys_clk) begin
    sync1_reg <= pins_raw;
    sync2_reg <= sync1_reg;
    prev_reg <= sync2_reg;
    mode_s1_reg <= single_clock_mode;
    mode_reg <= mode_s1_reg;
  end

  // edge finders on the synchronised clocks
  wire k_rise = sync2_reg.k && !prev_reg.k;
  wire kn_rise = sync2_reg.k_n && !prev_reg.k_n;
  wire c_rise = sync2_reg.c && !prev_reg.c;
  wire cn_rise = sync2_reg.c_n && !prev_reg.c_n;
  // output clocks follow the strap
  wire out_pos = mode_reg ? k_rise : c_rise;
  wire out_neg = mode_reg ? kn_rise : cn_rise;

  // selects only count on the K rising edge
  wire wr_start = k_rise && !sync2_reg.write_port_select_n;
  wire rd_start = k_rise && !sync2_reg.read_port_select_n;

  // write side capture
  logic wr_half_reg;
  dps_beat_t beat0_reg;
  dps_wentry_t wentry_reg;
  logic wpush_reg;
  wire dps_beat_t cur_beat = '{
    byte_write_select_n: sync2_reg.byte_write_select_n,
    data: sync2_reg.wdata};

  // beat 0 and its selects at K, beat 1 and write address at K-bar
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_half_reg <= 1'b0;
      wpush_reg <= 1'b0;
    end else begin
      wpush_reg <= 1'b0;
      if (wr_start) begin
        wr_half_reg <= 1'b1;
        beat0_reg <= cur_beat;
      end else if (kn_rise && wr_half_reg) begin
        wr_half_reg <= 1'b0;
        wentry_reg <= '{addr: sync2_reg.addr,
                        beat0: beat0_reg,
                        beat1: cur_beat};
        wpush_reg <= 1'b1;
      end
      // with the port deselected no beat is taken at all
    end
  end

  // write buffer between the pins and the array
  dps_wentry_t drain_entry;
  logic drain_valid;
  logic drain_ready;
  logic [EW-1:0] drain_bits;
  logic rd_fetch_reg;

  // a fetch owns the array for one cycle, stalling the drain
  assign drain_ready = !rd_fetch_reg;
  assign drain_entry = dps_wentry_t'(drain_bits);

  dps_fifo #(
    .WIDTH(EW),
    .DEPTH(WBUF_DEPTH)
  ) u_wbuf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_data(EW'(wentry_reg)),
    .in_valid(wpush_reg),
    .in_ready(wbuf_ready),
    .out_data(drain_bits),
    .out_valid(drain_valid),
    .out_ready(drain_ready)
  );

  // merge each beat with the stored word lane by lane
  wire [ARRAY_AW-1:0] w_row = drain_entry.addr[ARRAY_AW-1:0];
  wire [DATA_W-1:0] old0 = array_reg[0][w_row];
  wire [DATA_W-1:0] old1 = array_reg[1][w_row];
  logic [DATA_W-1:0] new0;
  logic [DATA_W-1:0] new1;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    // a lane with its select high keeps the old contents
    assign new0[l*DPS_LANE_W +: DPS_LANE_W] =
      drain_entry.beat0.byte_write_select_n[l]
        ? old0[l*DPS_LANE_W +: DPS_LANE_W]
        : drain_entry.beat0.data[l*DPS_LANE_W +: DPS_LANE_W];
    assign new1[l*DPS_LANE_W +: DPS_LANE_W] =
      drain_entry.beat1.byte_write_select_n[l]
        ? old1[l*DPS_LANE_W +: DPS_LANE_W]
        : drain_entry.beat1.data[l*DPS_LANE_W +: DPS_LANE_W];
  end

  // array write, one whole burst per drained entry
  always_ff @(posedge sys_clk) begin
    if (drain_valid && drain_ready) begin
      array_reg[0][w_row] <= new0;
      array_reg[1][w_row] <= new1;
    end
  end

  // read address taken at K; fetch follows one cycle later
  logic [ARRAY_AW-1:0] r_row_reg;
  logic [DATA_W-1:0] rbeat0_reg;
  logic [DATA_W-1:0] rbeat1_reg;
  logic rd_pend_reg;

  // limitation: a burst still in the buffer is not seen by a read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_fetch_reg <= 1'b0;
    end else begin
      rd_fetch_reg <= rd_start;
    end
    if (rd_start) begin
      r_row_reg <= sync2_reg.addr[ARRAY_AW-1:0];
    end
    if (rd_fetch_reg) begin
      rbeat0_reg <= array_reg[0][r_row_reg];
      rbeat1_reg <= array_reg[1][r_row_reg];
    end
  end

  // output sequencer
  dps_out_state_t out_state_reg;
  dps_out_state_t out_state_next;
  logic [DATA_W-1:0] rdata_next;
  logic oe_n_next;
  logic pend_next;

  // first beat leaves when a read waits and its fetch has landed
  wire beat0_go = out_pos && rd_pend_reg && !rd_fetch_reg
                  && out_state_reg != DPS_OUT_FIRST;
  // second beat parked as the first leaves
  logic [DATA_W-1:0] rhold1_reg;

  // back-to-back reads: the next fetch refills the read registers
  // before the negative output clock, so beat 1 must be held apart
  always_ff @(posedge sys_clk) begin
    if (beat0_go) begin
      rhold1_reg <= rbeat1_reg;
    end
  end

  // pending set by a new read, cleared when its first beat goes out
  always_comb begin
    out_state_next = out_state_reg;
    rdata_next = rdata;
    oe_n_next = rdata_oe_n;
    pend_next = rd_pend_reg;
    unique case (out_state_reg)
      DPS_OUT_IDLE, DPS_OUT_SECOND: begin
        if (beat0_go) begin
          // first beat of the waiting burst
          out_state_next = DPS_OUT_FIRST;
          rdata_next = rbeat0_reg;
          oe_n_next = 1'b0;
          pend_next = 1'b0;
        end else if (out_pos && out_state_reg == DPS_OUT_SECOND) begin
          // burst done and nothing waiting: release the pins
          out_state_next = DPS_OUT_IDLE;
          oe_n_next = 1'b1;
        end
      end
      DPS_OUT_FIRST: begin
        if (out_neg) begin
          out_state_next = DPS_OUT_SECOND;
          rdata_next = rhold1_reg;
        end
      end
    endcase
    if (rd_start) begin
      pend_next = 1'b1;
    end
  end

  // sequencer registers; pins stay released out of reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_state_reg <= DPS_OUT_IDLE;
      rdata <= '0;
      rdata_oe_n <= DPS_OE_N_RST;
      rd_pend_reg <= 1'b0;
    end else begin
      out_state_reg <= out_state_next;
      rdata <= rdata_next;
      rdata_oe_n <= oe_n_next;
      rd_pend_reg <= pend_next;
    end
  end

endmodule

`default_nettype wire

// [sim/dps_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// watches the read side of the memory pins
module dps_chk
  import dps_pkg::*;
(
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // clock pins and mode strap
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic single_clock_mode,
  // read select and outputs
  input wire logic read_port_select_n,
  input wire logic [DPS_WIDE_W-1:0] rdata,
  input wire logic rdata_oe_n,
  input wire logic wbuf_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // pin levels one cycle back, for edge finding
  logic k_reg, k_n_reg, c_reg, c_n_reg;
  // out-clock rises since the last read start, held at 3
  logic [1:0] cnt_reg;
  // cycles since the last out-clock rise, held at 15
  logic [3:0] pos_age_reg, any_age_reg;
  wire pos_rise = single_clock_mode ? k & ~k_reg : c & ~c_reg;
  wire neg_rise = single_clock_mode ? k_n & ~k_n_reg : c_n & ~c_n_reg;
  wire rd_start = k & ~k_reg & ~read_port_select_n;
  // edge history; a read start wins over a rise in the same cycle
  always_ff @(posedge sys_clk) begin
    {k_reg, k_n_reg, c_reg, c_n_reg} <= {k, k_n, c, c_n};
    if (!rst_n) begin
      {cnt_reg, pos_age_reg, any_age_reg} <= 10'h3FF;
    end else begin
      cnt_reg <= rd_start ? 2'h0 : cnt_reg + {1'h0, pos_rise & ~&cnt_reg};
      pos_age_reg <= pos_rise ? 4'h0 : pos_age_reg + {3'h0, ~&pos_age_reg};
      any_age_reg <= (pos_rise | neg_rise) ? 4'h0
                     : any_age_reg + {3'h0, ~&any_age_reg};
    end
  end
  property p_reset_idle;
    $rose(rst_n) |-> rdata_oe_n && rdata == '0 && wbuf_ready;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
  property p_read_answers;
    rd_start |-> ##[1:20] !rdata_oe_n;
  endproperty
  a_read_answers: assert property (p_read_answers)
    else $error("read start not answered");
  property p_on_after_read;
    $fell(rdata_oe_n) |-> cnt_reg <= 2'h1;
  endproperty
  a_on_after_read: assert property (p_on_after_read)
    else $error("read data driven without a read");
  property p_burst_held;
    $fell(rdata_oe_n) |=> !rdata_oe_n [*4];
  endproperty
  a_burst_held: assert property (p_burst_held)
    else $error("burst cut short");
  property p_tristate;
    cnt_reg[1] |-> ##4 rdata_oe_n;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("outputs still driven when idle");
  property p_off_on_pos;
    $rose(rdata_oe_n) |-> pos_age_reg inside {[2:3]};
  endproperty
  a_off_on_pos: assert property (p_off_on_pos)
    else $error("tristate away from a clock rise");
  property p_beat_on_c;
    !single_clock_mode && !rdata_oe_n && $changed(rdata)
      |-> any_age_reg inside {[2:3]};
  endproperty
  a_beat_on_c: assert property (p_beat_on_c)
    else $error("beat away from an output clock rise");
  property p_beat_on_k;
    single_clock_mode && !rdata_oe_n && $changed(rdata)
      |-> any_age_reg inside {[2:3]};
  endproperty
  a_beat_on_k: assert property (p_beat_on_k)
    else $error("beat away from an input clock rise");
endmodule
`default_nettype wire

// [sim/dps_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// controller side: clocks stand still except inside a call
module dps_ctl_model
  import dps_pkg::*;
(
  // bench clock and mode strap
  input wire logic sys_clk,
  input wire logic single_clock_mode,
  // clock pairs toward the memory
  output logic k,
  output logic k_n,
  output logic c,
  output logic c_n,
  // selects, shared address, write data
  output logic write_port_select_n,
  output logic read_port_select_n,
  output logic [3:0] byte_write_select_n,
  output logic [DPS_WIDE_AW-1:0] addr,
  output logic [DPS_WIDE_W-1:0] wdata,
  // read data coming back
  input wire logic [DPS_WIDE_W-1:0] rdata,
  input wire logic rdata_oe_n
);
  // in single clock mode the output clocks stand low
  wire c_on = ~single_clock_mode;
  // both ports idle until the first call
  initial begin
    {k, k_n, c, c_n} = 4'h0;
    {write_port_select_n, read_port_select_n} = 2'h3;
    byte_write_select_n = 4'hF;
    {addr, wdata} = '0;
  end
  // one 8-cycle period: 4 high on k, 3 on k_n plus the wait that
  // opens the next call; samples come late in each half
  task automatic cyc(input logic rd, wr, input logic [19:0] ra, wa,
    input logic [35:0] d0, d1, input logic [3:0] b0, b1,
    output logic [35:0] q0, q1, output logic o0, o1);
    @(negedge sys_clk);
    {k, k_n, c, c_n} = {2'h2, c_on, 1'h0};
    {read_port_select_n, write_port_select_n} = {~rd, ~wr};
    {addr, wdata, byte_write_select_n} = {ra, d0, b0};
    repeat (4) @(negedge sys_clk);
    {q0, o0} = {rdata, rdata_oe_n};
    {k, k_n, c, c_n} = {2'h1, 1'h0, c_on};
    {read_port_select_n, write_port_select_n} = 2'h3;
    {addr, wdata, byte_write_select_n} = {wa, d1, b1};
    repeat (3) @(negedge sys_clk);
    {q1, o1} = {rdata, rdata_oe_n};
  endtask
endmodule
`default_nettype wire

// [sim/dps_sram_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// random traffic through the controller model against a copy of the rows
module dps_sram_tb_top import dps_pkg::*;;
  // clock, reset, mode strap
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic scm = 1'h0;
  // pins between model and memory
  logic k, k_n, c, c_n, wr_sel_n, rd_sel_n, oe_n, wb_rdy;
  logic [3:0] bsel_n;
  logic [19:0] addr;
  logic [35:0] wdata, rdata, e0, e1;
  // expected rows, index is row and half; pend marks a read in flight
  logic [35:0] mem [128];
  logic pend = 1'h0;
  int bad_count = 0;
  int check_count = 0;
  initial forever #50 sys_clk = ~sys_clk;
  dps_ctl_model u_ctl (.sys_clk(sys_clk), .single_clock_mode(scm),
    .k(k), .k_n(k_n), .c(c),
    .c_n(c_n), .write_port_select_n(wr_sel_n), .read_port_select_n(rd_sel_n),
    .byte_write_select_n(bsel_n), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rdata_oe_n(oe_n));
  // small array keeps the expected copy short
  dps_sram #(.DATA_W(DPS_WIDE_W), .ARRAY_AW(6)) u_dut (.sys_clk(sys_clk),
    .rst_n(rst_n), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
    .single_clock_mode(scm), .write_port_select_n(wr_sel_n),
    .read_port_select_n(rd_sel_n), .byte_write_select_n(bsel_n),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rdata_oe_n(oe_n),
    .wbuf_ready(wb_rdy));
  // selected lanes take new data, the others keep the old
  function automatic logic [35:0] merge(logic [35:0] o, d, logic [3:0] b);
    for (int i = 0; i < 4; i++)
      if (!b[i]) o[i*9 +: 9] = d[i*9 +: 9];
    return o;
  endfunction
  task automatic chk(input logic [35:0] g, e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // one period; also judges the read of the period before
  task automatic op(input logic rd, wr, input logic [5:0] ra, wa,
    input logic [35:0] d0, d1, input logic [3:0] b0, b1);
    logic [35:0] q0, q1;
    logic o0, o1;
    u_ctl.cyc(rd, wr, {14'h0, ra}, {14'h0, wa}, d0, d1, b0, b1,
      q0, q1, o0, o1);
    if (pend) begin
      chk(q0, e0);
      chk(q1, e1);
      chk({35'h0, o1}, 36'h0);
    end else begin
      chk({35'h0, o0}, 36'h1);
    end
    // one burst per period drains long before the buffer fills
    chk({35'h0, wb_rdy}, 36'h1);
    // no forwarding: a read sees rows before this period's write
    {pend, e0, e1} = {rd, mem[{ra, 1'h0}], mem[{ra, 1'h1}]};
    if (wr) begin
      mem[{wa, 1'h0}] = merge(mem[{wa, 1'h0}], d0, b0);
      mem[{wa, 1'h1}] = merge(mem[{wa, 1'h1}], d1, b1);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(27));
    repeat (4) @(negedge sys_clk);
    rst_n = 1'h1;
    repeat (4) @(negedge sys_clk);
    // fill every row so later reads have a known answer
    for (int i = 0; i < 64; i++)
      op(0, 1, 0, 6'(i), 36'($urandom), 36'($urandom), 0, 0);
    $display("test fill done");
    // split lanes, all lanes off, write port off with live data
    op(0, 1, 0, 6'h5, '1, '0, 4'hA, 4'h5);
    op(1, 1, 6'h5, 6'h2, '0, '1, 4'hF, 4'hF);
    op(1, 0, 6'h2, 6'h2, '0, '0, 4'h0, 4'h0);
    op(1, 0, 6'h2, 6'h5, '0, '0, 4'hF, 4'hF);
    $display("test corners done");
    // random mix on the output clocks, then on the input clocks alone
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 120; i++)
        op(1'($urandom), 1'($urandom), 6'($urandom), 6'($urandom),
          36'({$urandom, $urandom}), 36'({$urandom, $urandom}),
          4'($urandom), 4'($urandom));
      op(0, 0, 0, 0, '0, '0, 4'hF, 4'hF);
      $display("test mix %0d done", m);
      scm = 1'h1;
    end
    op(0, 0, 0, 0, '0, '0, 4'hF, 4'hF);
    summarize();
  end
endmodule
bind dps_sram dps_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .k(k),
  .k_n(k_n), .c(c), .c_n(c_n), .single_clock_mode(single_clock_mode),
  .read_port_select_n(read_port_select_n), .rdata(rdata),
  .rdata_oe_n(rdata_oe_n), .wbuf_ready(wbuf_ready));
`default_nettype wire
